// ===== ibc_cycle_ctrl.sv
`timescale 1ns/1ps
//==========================================================================
// Overview of operation
// (RL1) Upper address lines 23..17 are bidirectional, covering 16 MByte.
// (RL2) IDE cycles put the IDE data word on the low sixteen address pins.
// (RL3) IDE cycles turn four upper address pins into drive chip selects.
// (RL4) IDE cycles use the three lowest upper pins as register index.
// (RL5) Upper data lines carry the high byte between bridge and ISA.
// (RL6) With input config low, upper data pins are inputs via a buffer.
// (RL7) With output config low, upper data pins drive an external latch.
// (RL8) Byte-high enable asserts when the upper data lane transfers a byte.
// (RL9) Byte-high enable stays negated throughout refresh cycles.
// (RL10) I/O read and write commands; the slave drives or latches data.
// (RL11) Memory read and write commands; the slave drives or latches data.
// (RL12) Standard memory commands are outputs, active only below 1 MByte.
// (RL13) Address latch enable high marks address and byte-high valid.
// (RL14) I/O 16-bit select makes a 16-bit I/O cycle, else 8-bit.
// (RL15) Memory 16-bit select low makes a 16-bit memory cycle.
// (RL16) Channel check assertion is treated as an error event.
// (RL17) Ready low inserts wait states until it returns high.
// (RL18) Channel check or system error raises a non-maskable interrupt.
// (RL19) ISA and IDE cycles never drive shared pins at once.
// (RL20) Upper data byte not driven for ISA while used as inputs.
module ibc_cycle_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Request side
   input wire logic req_valid,
   input wire ibc_pkg::ibc_kind_t req_kind,
   input wire logic [23:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic req_hi_byte,
   input wire logic [2:0] req_ide_index,
   input wire logic [3:0] req_ide_cs,
   input wire logic gp_input_cfg_bit,
   input wire logic gp_output_cfg_bit,
   input wire logic [7:0] gp_outputs_high,
   input wire logic gp_out_load,
   input wire logic serr_n_in,
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic rsp_wide,
   output logic chk_error,
   output logic [7:0] gp_inputs_high,
   output logic nmi,
   // Address and IDE shared pins
   input wire logic [15:0] sa_lo_in,
   output logic [15:0] sa_lo_out,
   output logic sa_lo_oe,
   output logic [3:0] sa_mid_out,
   output logic sa_mid_oe,
   input wire logic [6:0] la_in,
   output logic [6:0] la_out,
   output logic la_oe,
   // Data pins
   input wire logic [15:0] sd_in,
   output logic [15:0] sd_out,
   output logic [1:0] sd_oe,
   // Commands
   output logic sbhe_n,
   output logic bale,
   output logic ior_n,
   output logic iow_n,
   output logic memr_n,
   output logic memw_n,
   output logic smemr_n,
   output logic smemw_n,
   output logic ext_input_buffer_read_enable_n,
   output logic ext_output_latch_write_strobe,
   // Slave returns
   input wire logic iocs16_n,
   input wire logic memcs16_n,
   input wire logic iochck_n,
   input wire logic iochrdy
);
   //=======================================================================
   // Synchronisers
   logic [5:0] s1_ff, s2_ff;
   logic [15:0] sd1_ff, sd2_ff, sa1_ff, sa2_ff;
   logic [6:0] la1_ff, la2_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= 6'h3F;
         s2_ff <= 6'h3F;
         sd1_ff <= 16'h0000;
         sd2_ff <= 16'h0000;
         sa1_ff <= 16'h0000;
         sa2_ff <= 16'h0000;
         la1_ff <= 7'h00;
         la2_ff <= 7'h00;
      end else begin
         s1_ff <= {serr_n_in, iocs16_n, memcs16_n, iochck_n, iochrdy, 1'b1};
         s2_ff <= s1_ff;
         sd1_ff <= sd_in;
         sd2_ff <= sd1_ff;
         sa1_ff <= sa_lo_in;
         sa2_ff <= sa1_ff;
         la1_ff <= la_in;
         la2_ff <= la1_ff;
      end
   end
   logic serr_s, cs16_io_s, cs16_mem_s, chk_s, rdy_s;
   assign serr_s = ~s2_ff[5];
   assign cs16_io_s = ~s2_ff[4];
   assign cs16_mem_s = ~s2_ff[3];
   assign chk_s = ~s2_ff[2];
   assign rdy_s = s2_ff[1];

   function automatic logic is_ide(ibc_pkg::ibc_kind_t k);
      is_ide = (k == ibc_pkg::IBC_IDE_RD) || (k == ibc_pkg::IBC_IDE_WR);
   endfunction : is_ide
   function automatic logic is_write(ibc_pkg::ibc_kind_t k);
      is_write = (k == ibc_pkg::IBC_IO_WR) || (k == ibc_pkg::IBC_MEM_WR) ||
                 (k == ibc_pkg::IBC_IDE_WR);
   endfunction : is_write

   //=======================================================================
   // Cycle sequencer
   typedef enum {ST_IDLE, ST_ALE, ST_CMD, ST_REC} ibc_state_t;
   ibc_state_t st_ff, nxt_st;
   ibc_pkg::ibc_kind_t kind_ff, nxt_kind;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [23:0] addr_ff, nxt_addr;
   logic [15:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic hi_ff, nxt_hi, wide_ff, nxt_wide, ide_ff, nxt_ide;
   logic [2:0] idx_ff, nxt_idx;
   logic [3:0] cs_ff, nxt_cs;
   logic rsp_ff, nxt_rsp;

   always_comb begin
      nxt_st = st_ff;
      nxt_kind = kind_ff;
      nxt_cnt = cnt_ff;
      nxt_addr = addr_ff;
      nxt_wd = wd_ff;
      nxt_rd = rd_ff;
      nxt_hi = hi_ff;
      nxt_wide = wide_ff;
      nxt_ide = ide_ff;
      nxt_idx = idx_ff;
      nxt_cs = cs_ff;
      nxt_rsp = 1'b0;
      case (st_ff)
         ST_IDLE: begin
            // (RL19) One owner of shared pins
            if (req_valid) begin
               nxt_kind = req_kind;
               nxt_addr = req_addr;
               nxt_wd = req_wdata;
               // (RL9) Refresh never high byte
               nxt_hi = req_hi_byte && (req_kind != ibc_pkg::IBC_REFRESH);
               nxt_ide = is_ide(req_kind);
               nxt_idx = req_ide_index;
               nxt_cs = req_ide_cs;
               nxt_wide = is_ide(req_kind);
               nxt_cnt = is_ide(req_kind) ? ibc_pkg::IDE_CMD_CYC
                                          : ibc_pkg::ALE_CYC;
               nxt_st = is_ide(req_kind) ? ST_CMD : ST_ALE;
            end
         end
         ST_ALE: begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
               nxt_cnt = ibc_pkg::CMD_MIN_CYC;
               nxt_st = ST_CMD;
            end
         end
         ST_CMD: begin
            if (cnt_ff != 4'h0)
               nxt_cnt = cnt_ff - 4'h1;
            // (RL17) Wait while not ready
            else if (rdy_s || ide_ff) begin
               // (RL14) I/O width, late: selects decode the address
               if (kind_ff == ibc_pkg::IBC_IO_RD ||
                   kind_ff == ibc_pkg::IBC_IO_WR)
                  nxt_wide = cs16_io_s;
               // (RL15) Memory width from select
               else if (!ide_ff)
                  nxt_wide = cs16_mem_s;
               nxt_rd = ide_ff ? sa2_ff : sd2_ff;
               nxt_rsp = 1'b1;
               nxt_cnt = ibc_pkg::RECOV_CYC;
               nxt_st = ST_REC;
            end
         end
         ST_REC: begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1)
               nxt_st = ST_IDLE;
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= ST_IDLE;
         kind_ff <= ibc_pkg::IBC_IO_RD;
         cnt_ff <= 4'h0;
         addr_ff <= 24'h000000;
         wd_ff <= 16'h0000;
         rd_ff <= 16'h0000;
         hi_ff <= 1'b0;
         wide_ff <= 1'b0;
         ide_ff <= 1'b0;
         idx_ff <= 3'h0;
         cs_ff <= 4'hF;
         rsp_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         kind_ff <= nxt_kind;
         cnt_ff <= nxt_cnt;
         addr_ff <= nxt_addr;
         wd_ff <= nxt_wd;
         rd_ff <= nxt_rd;
         hi_ff <= nxt_hi;
         wide_ff <= nxt_wide;
         ide_ff <= nxt_ide;
         idx_ff <= nxt_idx;
         cs_ff <= nxt_cs;
         rsp_ff <= nxt_rsp;
      end
   end

   //=======================================================================
   // Pin drivers, all registered
   logic busy, cmd, isa_act, wr, mem, std;
   logic [15:0] nxt_sa;
   logic [6:0] nxt_la;
   logic [1:0] nxt_sdoe;
   assign busy = (st_ff != ST_IDLE);
   assign cmd = (st_ff == ST_CMD);
   assign isa_act = (st_ff == ST_ALE || st_ff == ST_CMD) && !ide_ff;
   assign wr = is_write(kind_ff);
   assign mem = kind_ff == ibc_pkg::IBC_MEM_RD ||
                kind_ff == ibc_pkg::IBC_MEM_WR;
   // (RL12) Standard commands below 1 MByte
   assign std = addr_ff < ibc_pkg::STD_MEM_LIMIT;

   always_comb begin
      // (RL2) IDE data on low address
      nxt_sa = ide_ff ? wd_ff : addr_ff[15:0];
      // (RL3) Chip selects on upper pins
      // (RL4) Register index on lowest pins
      nxt_la = addr_ff[ibc_pkg::LA_MSB:ibc_pkg::LA_LSB];
      if (ide_ff) begin
         nxt_la[ibc_pkg::IDX_W-1:0] = idx_ff;
         nxt_la[ibc_pkg::LA_CS_A1] = ~cs_ff[0];
         nxt_la[ibc_pkg::LA_CS_A3] = ~cs_ff[1];
         nxt_la[ibc_pkg::LA_CS_B1] = ~cs_ff[2];
         nxt_la[ibc_pkg::LA_CS_B3] = ~cs_ff[3];
      end
      // (RL5) High lane on writes
      // (RL20) No ISA drive in input mode
      nxt_sdoe = 2'b00;
      if (isa_act && wr) begin
         nxt_sdoe[0] = 1'b1;
         nxt_sdoe[1] = hi_ff && gp_input_cfg_bit;
      end
      // (RL7) Output mode drives latch data
      if (!busy && !gp_output_cfg_bit && gp_out_load)
         nxt_sdoe[1] = 1'b1;
   end

   logic gpo_ph_ff, gpi_ph_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sa_lo_out <= 16'h0000;
         sa_lo_oe <= 1'b0;
         sa_mid_out <= 4'h0;
         sa_mid_oe <= 1'b0;
         la_out <= 7'h00;
         la_oe <= 1'b0;
         sd_out <= 16'h0000;
         sd_oe <= 2'b00;
         sbhe_n <= 1'b1;
         bale <= 1'b0;
         ior_n <= 1'b1;
         iow_n <= 1'b1;
         memr_n <= 1'b1;
         memw_n <= 1'b1;
         smemr_n <= 1'b1;
         smemw_n <= 1'b1;
         gpo_ph_ff <= 1'b0;
         gpi_ph_ff <= 1'b0;
         ext_output_latch_write_strobe <= 1'b0;
         ext_input_buffer_read_enable_n <= 1'b1;
         gp_inputs_high <= 8'h00;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         rsp_wide <= 1'b0;
         chk_error <= 1'b0;
         nmi <= 1'b0;
      end else begin
         // (RL19) Shared pins driven by one cycle
         sa_lo_out <= nxt_sa;
         sa_lo_oe <= (isa_act && kind_ff != ibc_pkg::IBC_REFRESH) ||
                     (ide_ff && cmd && wr);
         sa_mid_out <= addr_ff[19:16];
         sa_mid_oe <= isa_act;
         // (RL1) Upper address tristated when idle
         la_out <= nxt_la;
         la_oe <= busy && (ide_ff || st_ff != ST_REC);
         sd_out <= (!busy && !gp_output_cfg_bit) ? {gp_outputs_high, 8'h00}
                                                 : wd_ff;
         sd_oe <= nxt_sdoe;
         // (RL8) High byte enable
         // (RL9) Negated on refresh
         sbhe_n <= !(isa_act && hi_ff);
         // (RL13) Latch enable marks valid address
         bale <= (st_ff == ST_ALE) && !ide_ff;
         // (RL10) I/O commands
         ior_n <= !(cmd && !ide_ff && kind_ff == ibc_pkg::IBC_IO_RD);
         iow_n <= !(cmd && !ide_ff && kind_ff == ibc_pkg::IBC_IO_WR);
         // (RL11) Memory commands
         memr_n <= !(cmd && !ide_ff && (kind_ff == ibc_pkg::IBC_MEM_RD ||
                     kind_ff == ibc_pkg::IBC_REFRESH));
         memw_n <= !(cmd && !ide_ff && kind_ff == ibc_pkg::IBC_MEM_WR);
         // (RL12) Standard strobes
         smemr_n <= !(cmd && std && (kind_ff == ibc_pkg::IBC_MEM_RD ||
                      kind_ff == ibc_pkg::IBC_REFRESH));
         smemw_n <= !(cmd && std && mem && wr);
         // (RL7) Latch strobe one cycle after data
         gpo_ph_ff <= !busy && !gp_output_cfg_bit && gp_out_load;
         ext_output_latch_write_strobe <= gpo_ph_ff;
         // (RL6) Buffer enable while idle in input mode
         gpi_ph_ff <= !busy && !gp_input_cfg_bit && !gp_out_load;
         ext_input_buffer_read_enable_n <= !gpi_ph_ff;
         if (gpi_ph_ff)
            gp_inputs_high <= sd2_ff[15:8];
         req_ready <= !busy && !req_valid;
         rsp_valid <= rsp_ff;
         rsp_rdata <= rd_ff;
         rsp_wide <= wide_ff;
         // (RL16) Channel check error
         chk_error <= chk_s;
         // (RL18) Non-maskable request
         nmi <= chk_s || serr_s;
      end
   end

   //=======================================================================
   // Checks
   sequence s_ale;
      bale;
   endsequence
   sequence s_cmd_follows;
      ##[1:8] (!ior_n || !iow_n || !memr_n || !memw_n);
   endsequence
   property p_bale_then_cmd;
      @(posedge clk) disable iff (!reset_n) s_ale ##1 !bale |-> s_cmd_follows;
   endproperty
   a_bale_then_cmd: assert property (p_bale_then_cmd) // RL13
      else $error("command did not follow address latch");
   property p_refresh_no_hi;
      @(posedge clk) disable iff (!reset_n)
         (kind_ff == ibc_pkg::IBC_REFRESH && busy) |=> sbhe_n;
   endproperty
   a_refresh_no_hi: assert property (p_refresh_no_hi) // RL9
      else $error("byte high enable during refresh");
   property p_std_limit;
      @(posedge clk) disable iff (!reset_n)
         (!std && busy) |=> (smemr_n && smemw_n);
   endproperty
   a_std_limit: assert property (p_std_limit) // RL12
      else $error("standard command above 1 MByte");
   property p_wait;
      @(posedge clk) disable iff (!reset_n)
         (cmd && cnt_ff == 4'h0 && !rdy_s && !ide_ff) |=> cmd;
   endproperty
   a_wait: assert property (p_wait) // RL17
      else $error("cycle ended while not ready");
   property p_nmi;
      @(posedge clk) disable iff (!reset_n) (chk_s || serr_s) |=> nmi;
   endproperty
   a_nmi: assert property (p_nmi) // RL18
      else $error("error without nmi");
   property p_no_hi_in;
      @(posedge clk) disable iff (!reset_n)
         (!gp_input_cfg_bit && busy) |=> !sd_oe[1];
   endproperty
   a_no_hi_in: assert property (p_no_hi_in) // RL20
      else $error("high byte driven in input mode");
   property p_ide_no_cmd;
      @(posedge clk) disable iff (!reset_n)
         ide_ff && busy |=> (ior_n && iow_n && !bale);
   endproperty
   a_ide_no_cmd: assert property (p_ide_no_cmd) // RL19
      else $error("isa command during ide cycle");
   property p_gpo;
      @(posedge clk) disable iff (!reset_n)
         ext_output_latch_write_strobe |-> $past(sd_oe[1]);
   endproperty
   a_gpo: assert property (p_gpo) // RL7
      else $error("latch strobe without data");
endmodule : ibc_cycle_ctrl

// ===== ibc_cycle_ctrl_tb.sv
`timescale 1ns/1ps
module ibc_cycle_ctrl_tb;
   logic clk = 0, reset_n = 0, req_valid = 0, req_hi_byte = 0;
   logic gp_input_cfg_bit = 1, gp_output_cfg_bit = 1, gp_out_load = 0;
   logic serr_n_in = 1, wide_io = 0, wide_mem = 0, chan_err = 0;
   ibc_pkg::ibc_kind_t req_kind = ibc_pkg::IBC_IO_RD;
   logic [23:0] req_addr = 24'h0, a_cap;
   logic [15:0] req_wdata = 16'h0, rd_data = 16'h0, d_cap, r_data;
   logic [2:0] req_ide_index = 3'h0;
   logic [3:0] req_ide_cs = 4'h0, sa_mid_out;
   logic [7:0] gp_outputs_high = 8'h0, gp_pins = 8'h0, wait_cyc = 8'h0;
   logic req_ready, rsp_valid, rsp_wide, chk_error, nmi, sa_lo_oe;
   logic la_oe, sbhe_n, bale, ior_n, iow_n, memr_n, memw_n, smemr_n;
   logic smemw_n, sa_mid_oe, iocs16_n, memcs16_n, iochck_n, iochrdy;
   logic ext_input_buffer_read_enable_n, ext_output_latch_write_strobe;
   logic [15:0] rsp_rdata, sa_lo_in, sa_lo_out, sd_in, sd_out, wr_seen;
   logic [7:0] gp_inputs_high;
   logic [6:0] la_in, la_out, l_cap;
   logic [1:0] sd_oe;
   logic mon = 0, s_sbhe, s_smem, s_sdhi, r_wide;
   int n_bale, lat, err_count = 0, cmp_count = 0, cyc = 0;

   ibc_cycle_ctrl u_dut (.*);
   ibc_slave_model u_slave (.*);

   always #2.5 clk = ~clk;
   //=======================================================================
   // Pin monitor, settled values
   always @(negedge clk) begin
      if (mon) begin
         if (bale) begin
            n_bale <= n_bale + 1;
            a_cap <= {la_out, sa_mid_out[0], sa_lo_out};
         end
         if (!sbhe_n) s_sbhe <= 1;
         if (!smemr_n || !smemw_n) s_smem <= 1;
         if (sd_oe[1]) s_sdhi <= 1;
         if (la_oe && sa_lo_oe) begin
            l_cap <= la_out;
            d_cap <= sa_lo_out;
         end
      end
   end
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   //=======================================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [23:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic go(input ibc_pkg::ibc_kind_t k, input logic [23:0] a,
      input logic [15:0] d, input logic hi);
      @(posedge clk);
      n_bale = 0;
      s_sbhe = 0;
      s_smem = 0;
      s_sdhi = 0;
      mon = 1;
      @(negedge clk);
      chk("ready", req_ready, 1);
      req_kind = k;
      req_addr = a;
      req_wdata = d;
      req_hi_byte = hi;
      req_valid = 1;
      lat = 0;
      while (rsp_valid !== 1'b1 && lat < 300) begin
         @(negedge clk);
         lat++;
      end
      chk("rsp", {23'h0, rsp_valid}, 24'h1);
      chk("ready_low", req_ready, 0);
      r_data = rsp_rdata;
      r_wide = rsp_wide;
      req_valid = 0;
      mon = 0;
      repeat (3) @(negedge clk);
   endtask : go
   //=======================================================================
   // Scenarios
   task automatic t_io();
      rd_data = 16'h5AC3;
      go(ibc_pkg::IBC_IO_RD, 24'h0002F8, 16'h0, 1'b0);
      chk("bale_len", 24'(n_bale), 24'(ibc_pkg::ALE_CYC));
      chk("io_addr", a_cap[16:0], 24'h02F8);
      chk("wide8", r_wide, 0);
      chk("rd8", r_data[7:0], 24'hC3);
      chk("io_smem", s_smem, 0);
      wide_io = 1;
      go(ibc_pkg::IBC_IO_RD, 24'h000170, 16'h0, 1'b1);
      chk("wide16", r_wide, 1);
      chk("rd16", r_data, 24'h5AC3);
      chk("sbhe_on", s_sbhe, 1);
      go(ibc_pkg::IBC_IO_WR, 24'h000172, 16'h9E17, 1'b1);
      chk("wr16", wr_seen, 24'h9E17);
      chk("hi_lane", s_sdhi, 1);
      wide_io = 0;
      $display("test io done");
   endtask : t_io
   task automatic t_mem();
      wide_mem = 1;
      rd_data = 16'h3CA6;
      go(ibc_pkg::IBC_MEM_RD, 24'h0E1234, 16'h0, 1'b1);
      chk("smem_lo", s_smem, 1);
      chk("mwide", r_wide, 1);
      chk("mrd", r_data, 24'h3CA6);
      chk("maddr", a_cap, 24'h0E1234);
      go(ibc_pkg::IBC_MEM_WR, 24'hC8A5F0, 16'h71B4, 1'b1);
      chk("smem_hi", s_smem, 0);
      chk("mwr", wr_seen, 24'h71B4);
      chk("la_addr", a_cap, 24'hC8A5F0);
      wide_mem = 0;
      go(ibc_pkg::IBC_MEM_WR, 24'h0FFFFF, 16'h00D2, 1'b0);
      chk("smem_edge", s_smem, 1);
      chk("mwide8", r_wide, 0);
      chk("mwr8", wr_seen[7:0], 24'hD2);
      go(ibc_pkg::IBC_MEM_RD, 24'h100000, 16'h0, 1'b0);
      chk("smem_1m", s_smem, 0);
      go(ibc_pkg::IBC_REFRESH, 24'h0, 16'h0, 1'b1);
      chk("sbhe_ref", s_sbhe, 0);
      $display("test mem done");
   endtask : t_mem
   task automatic t_wait();
      int l0;
      go(ibc_pkg::IBC_IO_RD, 24'h000300, 16'h0, 1'b0);
      l0 = lat;
      wait_cyc = 8'h14;
      go(ibc_pkg::IBC_IO_RD, 24'h000300, 16'h0, 1'b0);
      // Ready low overlaps the minimum command, so only the excess shows
      chk("wait", {23'h0, lat >= l0 + 10 && lat <= l0 + 24}, 24'h1);
      wait_cyc = 8'h00;
      $display("test wait done");
   endtask : t_wait
   task automatic t_ide();
      req_ide_index = 3'h5;
      req_ide_cs = 4'h2;
      go(ibc_pkg::IBC_IDE_WR, 24'h0, 16'hB00F, 1'b1);
      chk("ide_data", d_cap, 24'hB00F);
      chk("ide_cs", l_cap[6:3], 24'hD);
      chk("ide_idx", l_cap[2:0], 24'h5);
      chk("ide_bale", 24'(n_bale), 24'h0);
      rd_data = 16'h6E2D;
      go(ibc_pkg::IBC_IDE_RD, 24'h0, 16'h0, 1'b1);
      chk("ide_rd", r_data, 24'h6E2D);
      chk("ide_wide", r_wide, 1);
      $display("test ide done");
   endtask : t_ide
   task automatic t_err();
      chan_err = 1;
      repeat (4) @(negedge clk);
      chk("chk_on", chk_error, 1);
      chk("nmi_chk", nmi, 1);
      chan_err = 0;
      serr_n_in = 0;
      repeat (4) @(negedge clk);
      chk("chk_off", chk_error, 0);
      chk("nmi_serr", nmi, 1);
      serr_n_in = 1;
      repeat (4) @(negedge clk);
      chk("nmi_off", nmi, 0);
      $display("test err done");
   endtask : t_err
   task automatic t_gp();
      gp_input_cfg_bit = 0;
      gp_pins = 8'h6B;
      repeat (8) @(negedge clk);
      chk("gpi", gp_inputs_high, 24'h6B);
      chk("ext_input_buffer_read_enable", ext_input_buffer_read_enable_n, 0);
      go(ibc_pkg::IBC_IO_WR, 24'h000310, 16'hF00D, 1'b1);
      chk("sd_hi_off", s_sdhi, 0);
      gp_input_cfg_bit = 1;
      gp_output_cfg_bit = 0;
      gp_outputs_high = 8'h4E;
      gp_out_load = 1;
      lat = 0;
      while (ext_output_latch_write_strobe !== 1'b1 && lat < 20) begin
         @(negedge clk);
         lat++;
      end
      chk("gpo", {sd_oe[1], sd_out[15:8]}, 24'h14E);
      chk("ext_output_latch_write_strobe", ext_output_latch_write_strobe, 1);
      gp_out_load = 0;
      gp_output_cfg_bit = 1;
      repeat (3) @(negedge clk);
      $display("test gp done");
   endtask : t_gp
   //=======================================================================
   // Verdict
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (3) @(negedge clk);
      reset_n = 1;
      @(negedge clk);
      t_io();
      t_mem();
      t_wait();
      t_ide();
      t_err();
      t_gp();
      give_verdict();
   end
endmodule : ibc_cycle_ctrl_tb

// ===== ibc_pkg.sv
package ibc_pkg;
   // Address widths
   localparam int SA_W = 20;
   localparam int LA_LSB = 17;
   localparam int LA_MSB = 23;
   localparam int LA_W = 7;
   // 1 MByte boundary for the standard memory commands
   localparam logic [23:0] STD_MEM_LIMIT = 24'h100000;
   // Upper address pins reused for IDE selects and register index
   localparam int IDX_W = 3;
   localparam int LA_CS_A1 = 3;
   localparam int LA_CS_A3 = 4;
   localparam int LA_CS_B1 = 5;
   localparam int LA_CS_B3 = 6;
   // Cycle timing in clock cycles
   localparam logic [3:0] ALE_CYC = 4'h2;
   localparam logic [3:0] CMD_MIN_CYC = 4'h6;
   localparam logic [3:0] IDE_CMD_CYC = 4'h4;
   localparam logic [3:0] RECOV_CYC = 4'h2;
   // Request kinds
   typedef enum logic [2:0] {
      IBC_IO_RD, IBC_IO_WR, IBC_MEM_RD, IBC_MEM_WR, IBC_REFRESH,
      IBC_IDE_RD, IBC_IDE_WR
   } ibc_kind_t;
endpackage : ibc_pkg

// ===== ibc_slave_model.sv
`timescale 1ns/1ps
//==========================================================================
// Slave and bus model
module ibc_slave_model (
   // Clock
   input wire logic clk,
   // Bench controls
   input wire logic wide_io,
   input wire logic wide_mem,
   input wire logic chan_err,
   input wire logic [7:0] wait_cyc,
   input wire logic [15:0] rd_data,
   input wire logic [7:0] gp_pins,
   output logic [15:0] wr_seen,
   // Bridge pins
   input wire logic [15:0] sa_lo_out,
   input wire logic sa_lo_oe,
   input wire logic sa_mid_oe,
   input wire logic [6:0] la_out,
   input wire logic la_oe,
   input wire logic [15:0] sd_out,
   input wire logic [1:0] sd_oe,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic ext_input_buffer_read_enable_n,
   output logic [15:0] sa_lo_in,
   output logic [6:0] la_in,
   output logic [15:0] sd_in,
   output logic iocs16_n,
   output logic memcs16_n,
   output logic iochck_n,
   output logic iochrdy
);
   logic [7:0] wait_ff = 8'h00;
   logic cmd_ff = 1'b0;
   // Released lines toggle so a stale value never looks valid
   logic [15:0] pat = 16'hA5C3;
   logic cmd;
   logic rd;
   assign cmd = !(ior_n && iow_n && memr_n && memw_n);
   assign rd = !(ior_n && memr_n);
   always @(posedge clk) begin
      pat <= ~pat;
      cmd_ff <= cmd;
      if (cmd && !cmd_ff)
         wait_ff <= wait_cyc;
      else if (wait_ff != 8'h00)
         wait_ff <= wait_ff - 8'h01;
      if (!iow_n || !memw_n)
         wr_seen <= sd_out;
   end
   assign iochrdy = !(cmd && (wait_ff != 8'h00 ||
      (!cmd_ff && wait_cyc != 8'h00)));
   // width selects decode the driven address
   assign iocs16_n = !(wide_io && sa_lo_oe);
   assign memcs16_n = !(wide_mem && la_oe);
   assign iochck_n = !chan_err;
   assign la_in = la_oe ? la_out : pat[6:0];
   // drive returns its data word on an IDE read
   assign sa_lo_in = sa_lo_oe ? sa_lo_out :
      (la_oe && !sa_mid_oe) ? rd_data : pat;
   assign sd_in[7:0] = sd_oe[0] ? sd_out[7:0] : rd ? rd_data[7:0] : pat[7:0];
   assign sd_in[15:8] = sd_oe[1] ? sd_out[15:8] :
      !ext_input_buffer_read_enable_n ? gp_pins :
      (rd && (wide_io || wide_mem)) ? rd_data[15:8] : pat[15:8];
endmodule : ibc_slave_model
